// ===== design/pwmsd_top.sv
// Purpose: Auto-shutdown, restart and dead-band logic for a four-pin PWM
// Assumes: i_clk is the instruction clock; inputs synchronous to it
// Notes:   Pins are two signals each; the pad resolves the level
//
// How it works
// R1: Flag bit 7 reads one during shutdown
// R2: Three-bit source select decodes comparators and pin
// R3: Pair A/C shutdown: low, high or tri-state
// R4: Pair B/D shutdown: low, high or tri-state
// R5: Shutdown is level-based, persists while asserted
// R6: Flag writes ignored while condition is asserted
// R7: Modulation resumes only at next period start
// R8: Auto-restart clears flag when condition drops
// R9: Without auto-restart software clears the flag
// R10: Dead-band delays only inactive-to-active edges
// R11: Seven-bit count of instruction cycles delay
// R12: Shutdown event sets flag and forces pins
// R13: Firmware setting the flag is a shutdown event
// R14: Half-bridge drives PWM on A, complement B
// R15: Count above duty keeps output inactive all cycle
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "pwmsd_cfg.svh"

module pwmsd_top
	import pwmsd_pkg::*;
#(
	parameter int DB_W = 7          // Dead-band counter width
) (
	// Clock and reset
	input  wire logic                     i_clk,
	input  wire logic                     i_rst,
	// Register port
	input  wire logic [`PWMSD_ADDR_W-1:0] i_addr,
	input  wire logic [7:0]               i_wdata,
	input  wire logic                     i_wr,
	input  wire logic                     i_rd,
	output logic      [7:0]               o_rdata,
	// Modulator side
	input  wire logic                     i_pwm_a,
	input  wire logic                     i_pwm_b,
	input  wire logic                     i_pwm_c,
	input  wire logic                     i_pwm_d,
	input  wire logic                     i_period_start,
	input  wire logic                     i_half_bridge,
	// Shutdown sources
	input  wire logic                     i_cmp_one,
	input  wire logic                     i_cmp_two,
	input  wire logic                     i_int_pin,
	// Output pins
	output logic                          o_output_a,
	output logic                          o_output_a_oe,
	output logic                          o_output_b,
	output logic                          o_output_b_oe,
	output logic                          o_output_c,
	output logic                          o_output_c_oe,
	output logic                          o_output_d,
	output logic                          o_output_d_oe,
	// Interrupt
	output logic                          o_irq
);

	// Registers
	logic [2:0]      shutdown_source_select;  // Source choice
	logic [1:0]      pair_ac_shutdown_state;  // A/C safe state
	logic [1:0]      pair_bd_shutdown_state;  // B/D safe state
	logic            shutdown_event_flag;     // Shutdown status
	logic            auto_restart_enable;     // Hardware restart
	logic [DB_W-1:0] deadband_count;          // Delay in cycles
	logic [7:0]      capture_compare_pwm_control; // Mode byte
	logic [1:0]      irq_status;              // Sticky events
	logic [1:0]      irq_mask;                // Event enables

	// Internal
	logic            sd_cond;         // Selected source level
	logic            fw_set;          // Firmware sets the flag
	logic            fw_clr;          // Firmware clears the flag
	logic            next_flag;       // Flag next value
	logic            flag_q;          // Flag one cycle ago
	pwmsd_state_t    state;           // Pin pair condition
	logic            hold;            // Pins in safe state
	logic [1:0]      db_raw;          // Half-bridge A/B requests
	logic [1:0]      db_out;          // Delayed A/B
	logic            mod_a;           // A before shutdown
	logic            mod_b;           // B before shutdown
	logic [1:0]      irq_set;         // Events this cycle

	// Source decode, evaluated as a level each cycle
	always_comb begin
		sd_cond = 1'b0;
		if (shutdown_source_select[`PWMSD_SRC_CMP1] && i_cmp_one) begin // R2
			sd_cond = 1'b1;
		end
		if (shutdown_source_select[`PWMSD_SRC_CMP2] && i_cmp_two) begin // R2
			sd_cond = 1'b1;
		end
		if (shutdown_source_select[`PWMSD_SRC_PIN] && !i_int_pin) begin // R2
			sd_cond = 1'b1;
		end
	end

	// Firmware access to the flag bit
	assign fw_set = i_wr && (i_addr == `PWMSD_OFF_SDCTL) &&
		i_wdata[`PWMSD_SD_FLAG];
	assign fw_clr = i_wr && (i_addr == `PWMSD_OFF_SDCTL) &&
		!i_wdata[`PWMSD_SD_FLAG] && !sd_cond; // R6 R9

	// Flag next value: a live condition always wins
	always_comb begin
		next_flag = shutdown_event_flag;
		if (sd_cond) begin
			next_flag = 1'b1; // R5 R12
		end else if (fw_set) begin
			next_flag = 1'b1; // R13
		end else if (fw_clr) begin
			next_flag = 1'b0; // R9
		end else if (auto_restart_enable) begin
			next_flag = 1'b0; // R8
		end
	end

	// Shutdown control register
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			shutdown_event_flag    <= 1'b0;
			shutdown_source_select <= 3'h0;
			pair_ac_shutdown_state <= 2'h0;
			pair_bd_shutdown_state <= 2'h0;
		end else begin
			shutdown_event_flag <= next_flag; // R1
			if (i_wr && i_addr == `PWMSD_OFF_SDCTL) begin
				shutdown_source_select <=
					i_wdata[`PWMSD_SD_SRC_HI:`PWMSD_SD_SRC_LO];
				pair_ac_shutdown_state <=
					i_wdata[`PWMSD_SD_AC_HI:`PWMSD_SD_AC_LO];
				pair_bd_shutdown_state <=
					i_wdata[`PWMSD_SD_BD_HI:`PWMSD_SD_BD_LO];
			end
		end
	end

	// Restart/dead-band and mode registers
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			auto_restart_enable         <= 1'b0;
			deadband_count              <= '0;
			capture_compare_pwm_control <= `PWMSD_RST_BYTE;
		end else if (i_wr) begin
			if (i_addr == `PWMSD_OFF_RDCTL) begin
				auto_restart_enable <= i_wdata[`PWMSD_RD_RESTART];
				deadband_count <=
					DB_W'(i_wdata[`PWMSD_RD_DB_HI:`PWMSD_RD_DB_LO]);
			end
			if (i_addr == `PWMSD_OFF_CCPCTL) begin
				capture_compare_pwm_control <= i_wdata;
			end
		end
	end

	// Pin condition: safe state until a period boundary after restart
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= PWMSD_RUN;
		end else begin
			case (state)
				PWMSD_RUN: begin
					if (next_flag) begin
						state <= PWMSD_HOLD; // R12
					end
				end
				PWMSD_HOLD: begin
					if (!next_flag) begin
						state <= PWMSD_WAIT; // R7
					end
				end
				PWMSD_WAIT: begin
					if (next_flag) begin
						state <= PWMSD_HOLD;
					end else if (i_period_start) begin
						state <= PWMSD_RUN; // R7
					end
				end
				default: begin
					state <= PWMSD_HOLD;
				end
			endcase
		end
	end

	// Safe state also covers the cycle the flag is being set
	assign hold = (state != PWMSD_RUN) || next_flag; // R12

	// Half-bridge pair: PWM on A, complement on B
	assign db_raw = {!i_pwm_a, i_pwm_a}; // R14

	// Dead-band delay per half-bridge output
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_db
			logic            prev;  // Request one cycle ago
			logic [DB_W-1:0] cnt;   // Remaining delay
			// Count restarts on each inactive-to-active edge
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					prev <= 1'b0;
					cnt  <= '0;
				end else begin
					prev <= db_raw[g];
					if (db_raw[g] && !prev) begin
						cnt <= deadband_count; // R10 R11
					end else if (!db_raw[g]) begin
						cnt <= '0; // R15
					end else if (cnt != '0) begin
						cnt <= cnt - DB_W'(`PWMSD_DB_ONE); // R11
					end
				end
			end
			// Active only once the delay has run out
			assign db_out[g] = db_raw[g] && prev &&
				(cnt == '0 || cnt == DB_W'(`PWMSD_DB_ONE)); // R10 R15
		end
	endgenerate

	// Zero delay passes the edge without extra wait
	assign mod_a = i_half_bridge ?
		(deadband_count == '0 ? i_pwm_a : db_out[0]) : i_pwm_a;
	assign mod_b = i_half_bridge ?
		(deadband_count == '0 ? !i_pwm_a : db_out[1]) : i_pwm_b;

	// Pin drivers, registered
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_output_a    <= 1'b0;
			o_output_a_oe <= 1'b0;
			o_output_b    <= 1'b0;
			o_output_b_oe <= 1'b0;
			o_output_c    <= 1'b0;
			o_output_c_oe <= 1'b0;
			o_output_d    <= 1'b0;
			o_output_d_oe <= 1'b0;
		end else if (hold) begin
			// Safe states per pair
			o_output_a    <= pair_ac_shutdown_state[`PWMSD_PSS_LVL]; // R3
			o_output_c    <= pair_ac_shutdown_state[`PWMSD_PSS_LVL]; // R3
			o_output_a_oe <= !pair_ac_shutdown_state[`PWMSD_PSS_TRI]; // R3
			o_output_c_oe <= !pair_ac_shutdown_state[`PWMSD_PSS_TRI]; // R3
			o_output_b    <= pair_bd_shutdown_state[`PWMSD_PSS_LVL]; // R4
			o_output_d    <= pair_bd_shutdown_state[`PWMSD_PSS_LVL]; // R4
			o_output_b_oe <= !pair_bd_shutdown_state[`PWMSD_PSS_TRI]; // R4
			o_output_d_oe <= !pair_bd_shutdown_state[`PWMSD_PSS_TRI]; // R4
		end else begin
			// Normal modulation
			o_output_a    <= mod_a;
			o_output_b    <= mod_b;
			o_output_c    <= i_pwm_c;
			o_output_d    <= i_pwm_d;
			o_output_a_oe <= 1'b1;
			o_output_b_oe <= 1'b1;
			o_output_c_oe <= !i_half_bridge;
			o_output_d_oe <= !i_half_bridge;
		end
	end

	// Flag history for event detection
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= shutdown_event_flag;
		end
	end

	// Events: entry into shutdown and flag cleared
	assign irq_set[`PWMSD_IRQ_ENTER]  = shutdown_event_flag && !flag_q;
	assign irq_set[`PWMSD_IRQ_RESUME] = !shutdown_event_flag && flag_q;

	// Sticky status, write one to clear, new event wins
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_status <= `PWMSD_RST_IRQ;
		end else if (i_wr && i_addr == `PWMSD_OFF_IRQSTAT) begin
			irq_status <= (irq_status & ~i_wdata[1:0]) | irq_set;
		end else begin
			irq_status <= irq_status | irq_set;
		end
	end

	// Interrupt mask
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			irq_mask <= `PWMSD_RST_IRQ;
		end else if (i_wr && i_addr == `PWMSD_OFF_IRQMASK) begin
			irq_mask <= i_wdata[1:0];
		end
	end

	// Level interrupt output
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_status & irq_mask);
		end
	end

	// Read data, valid the cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= `PWMSD_RST_BYTE;
		end else if (i_rd) begin
			case (i_addr)
				`PWMSD_OFF_SDCTL: begin
					o_rdata <= {shutdown_event_flag, shutdown_source_select,
						pair_ac_shutdown_state, pair_bd_shutdown_state}; // R1
				end
				`PWMSD_OFF_RDCTL: begin
					o_rdata <= {auto_restart_enable, 7'(deadband_count)};
				end
				`PWMSD_OFF_CCPCTL: begin
					o_rdata <= capture_compare_pwm_control;
				end
				`PWMSD_OFF_IRQSTAT: begin
					o_rdata <= {6'h00, irq_status};
				end
				`PWMSD_OFF_IRQMASK: begin
					o_rdata <= {6'h00, irq_mask};
				end
				default: begin
					o_rdata <= `PWMSD_RST_BYTE;
				end
			endcase
		end else begin
			o_rdata <= `PWMSD_RST_BYTE;
		end
	end

endmodule : pwmsd_top

`default_nettype wire

// ===== design/pwmsd_cfg.svh
// Purpose: Offsets, field positions and reset values of the shutdown block
// Assumes: Word-indexed register port, eight data bits per register
// Notes:   Included by the design file and the property checker
`ifndef PWMSD_CFG_SVH
`define PWMSD_CFG_SVH

// Register indices on the plain register port
`define PWMSD_ADDR_W        3
`define PWMSD_OFF_SDCTL     3'h0
`define PWMSD_OFF_RDCTL     3'h1
`define PWMSD_OFF_CCPCTL    3'h2
`define PWMSD_OFF_IRQSTAT   3'h3
`define PWMSD_OFF_IRQMASK   3'h4

// Reset values
`define PWMSD_RST_BYTE      8'h00
`define PWMSD_RST_IRQ       2'h0

// Shutdown control fields
`define PWMSD_SD_FLAG       7
`define PWMSD_SD_SRC_HI     6
`define PWMSD_SD_SRC_LO     4
`define PWMSD_SD_AC_HI      3
`define PWMSD_SD_AC_LO      2
`define PWMSD_SD_BD_HI      1
`define PWMSD_SD_BD_LO      0

// Restart and dead-band control fields
`define PWMSD_RD_RESTART    7
`define PWMSD_RD_DB_HI      6
`define PWMSD_RD_DB_LO      0

// Source select bits inside the three-bit field
`define PWMSD_SRC_CMP1      0
`define PWMSD_SRC_CMP2      1
`define PWMSD_SRC_PIN       2

// Interrupt status bits
`define PWMSD_IRQ_ENTER     0
`define PWMSD_IRQ_RESUME    1

// Pair state code bits
`define PWMSD_PSS_TRI       1
`define PWMSD_PSS_LVL       0

// Dead-band counter
`define PWMSD_DB_ZERO       7'h00
`define PWMSD_DB_ONE        7'h01

`endif

// ===== design/pwmsd_pkg.sv
// Purpose: Types shared by the shutdown and dead-band block
// Assumes: Constants live in pwmsd_cfg.svh
// Notes:   Types only
`default_nettype none

package pwmsd_pkg;

	// Output condition of the pin pairs
	typedef enum logic [1:0] {
		PWMSD_RUN,      // Normal modulation
		PWMSD_HOLD,     // Shutdown flag set, pins in safe state
		PWMSD_WAIT      // Flag cleared, waiting for period start
	} pwmsd_state_t;

endpackage : pwmsd_pkg

`default_nettype wire

// ===== testbench/pwmsd_props.sv
// Purpose: Port-level checks of the shutdown and dead-band block
// Assumes: Shadow fields follow writes to the control registers
// Notes:   Bound into pwmsd_top after the module
`timescale 1ns/1ns
`default_nettype none
`include "pwmsd_cfg.svh"

module pwmsd_props (
	// Clock, reset and register port
	input wire logic       i_clk, i_rst, i_wr, i_rd,
	input wire logic [`PWMSD_ADDR_W-1:0] i_addr,
	input wire logic [7:0] i_wdata, o_rdata,
	// Modulator side and sources
	input wire logic       i_pwm_a, i_period_start, i_half_bridge,
	input wire logic       i_cmp_one, i_cmp_two, i_int_pin,
	// Pins and interrupt
	input wire logic       o_output_a, o_output_b, o_output_c,
	input wire logic       o_output_d, o_output_a_oe, o_output_b_oe,
	input wire logic       o_output_c_oe, o_output_d_oe, o_irq
);
	logic [2:0] s_src; // Selected sources
	logic [1:0] s_ac;  // Pair A/C safe code
	logic [1:0] s_bd;  // Pair B/D safe code
	logic [6:0] s_db;  // Dead-band count
	logic [1:0] s_msk; // Interrupt mask
	// Shadow of the written control fields
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			{s_src, s_ac, s_bd, s_db, s_msk} <= '0;
		end else if (i_wr && i_addr == `PWMSD_OFF_SDCTL) begin
			{s_src, s_ac, s_bd} <= i_wdata[6:0];
		end else if (i_wr && i_addr == `PWMSD_OFF_RDCTL) begin
			s_db <= i_wdata[6:0];
		end else if (i_wr && i_addr == `PWMSD_OFF_IRQMASK) begin
			s_msk <= i_wdata[1:0];
		end
	end
	// A selected source is asserted
	wire logic act = (s_src[0] & i_cmp_one) | (s_src[1] & i_cmp_two)
		| (s_src[2] & ~i_int_pin);
	// Pins show the programmed safe state
	wire logic safe = (s_ac[1] ? !(o_output_a_oe | o_output_c_oe)
		: o_output_a_oe & o_output_c_oe & o_output_a == s_ac[0]
		& o_output_c == s_ac[0]) & (s_bd[1]
		? !(o_output_b_oe | o_output_d_oe)
		: o_output_b_oe & o_output_d_oe & o_output_b == s_bd[0]
		& o_output_d == s_bd[0]);

	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// Source seen, then calm cycles with no period start
	sequence s_on;
		act;
	endsequence
	sequence s_quiet;
		(!act && !i_period_start) [*3];
	endsequence

	a_safe_holds: assert property (act |=> safe)
		else $error("pins left safe state during shutdown");
	a_no_midperiod: assert property (s_on ##1 s_quiet |=> safe)
		else $error("output resumed before a period start");
	a_irq_masked: assert property ((s_msk == 2'h0) [*2] |=> !o_irq)
		else $error("interrupt raised with all sources masked");
	a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
		else $error("read data not zero outside a read");
	a_rdata_unmap: assert property (i_rd && i_addr > 3'h4 |=> !o_rdata)
		else $error("unmapped index returned data");
	a_fall_fast: assert property (i_half_bridge && !i_pwm_a
		&& s_ac == 2'h0 |=> !o_output_a)
		else $error("output a turned off late");
	a_b_complement: assert property (i_half_bridge && i_pwm_a
		&& s_bd == 2'h0 |=> !o_output_b)
		else $error("output b not complement of a");
	a_db_rise: assert property (i_half_bridge && s_db != 7'h00
		&& s_ac == 2'h0 && $rose(i_pwm_a) |=> !o_output_a)
		else $error("active edge of a not delayed");
endmodule : pwmsd_props

bind pwmsd_top pwmsd_props u_props (.i_clk, .i_rst, .i_wr, .i_rd,
	.i_addr, .i_wdata, .o_rdata, .i_pwm_a, .i_period_start,
	.i_half_bridge, .i_cmp_one, .i_cmp_two, .i_int_pin, .o_output_a,
	.o_output_b, .o_output_c, .o_output_d, .o_output_a_oe,
	.o_output_b_oe, .o_output_c_oe, .o_output_d_oe, .o_irq);

`default_nettype wire

// ===== testbench/pwmsd_bridge.sv
// Purpose: Switch-driver inputs as seen at the four output pins
// Assumes: Each pin carries a pull-down that keeps its switch off
// Notes:   A released pin reads low
`timescale 1ns/1ns
`default_nettype none

module pwmsd_bridge (
	// Pin drive from the block
	input  wire logic [3:0] i_lvl,
	input  wire logic [3:0] i_oe,
	// Level seen by the drivers
	output wire logic [3:0] o_pin
);
	// Driven pins show their level, released pins the pull-down
	assign o_pin = i_lvl & i_oe;
endmodule : pwmsd_bridge

`default_nettype wire

// ===== testbench/pwmsd_top_tb_top.sv
// Purpose: Self-checking bench of the shutdown and dead-band block
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Pin vectors are ordered d, c, b, a
`timescale 1ns/1ns
`default_nettype none

module pwmsd_top_tb_top;
	logic       i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0;
	logic [2:0] i_addr = 3'h0;
	logic [7:0] i_wdata = 8'h00;
	logic       i_pwm_a = 1'b0, i_pwm_b = 1'b0, i_pwm_c = 1'b0;
	logic       i_pwm_d = 1'b0, i_period_start = 1'b0;
	logic       i_half_bridge = 1'b0, i_cmp_one = 1'b0;
	logic       i_cmp_two = 1'b0, i_int_pin = 1'b1;
	logic [7:0] o_rdata;
	logic       o_output_a, o_output_b, o_output_c, o_output_d, o_irq;
	logic       o_output_a_oe, o_output_b_oe, o_output_c_oe;
	logic       o_output_d_oe;
	wire  [3:0] pin; // Levels at the drivers
	wire  [3:0] oe = {o_output_d_oe, o_output_c_oe, o_output_b_oe,
		o_output_a_oe};
	int         failures = 0, checked = 0;

	// Block under test and its far side
	pwmsd_top uut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd,
		.o_rdata, .i_pwm_a, .i_pwm_b, .i_pwm_c, .i_pwm_d, .i_period_start,
		.i_half_bridge, .i_cmp_one, .i_cmp_two, .i_int_pin, .o_output_a,
		.o_output_a_oe, .o_output_b, .o_output_b_oe, .o_output_c,
		.o_output_c_oe, .o_output_d, .o_output_d_oe, .o_irq);
	pwmsd_bridge u_drv (.i_lvl({o_output_d, o_output_c, o_output_b,
		o_output_a}), .i_oe(oe), .o_pin(pin));

	// Clock of 4 ns
	initial begin
		forever #2 i_clk = ~i_clk;
	end

	task automatic wrap_up;
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	// Read and compare in the cycle after the strobe
	task automatic rdchk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1 chk(o_rdata, exp);
	endtask : rdchk

	// Raise or drop one shutdown source
	task automatic drive_src(input int k, input logic on);
		@(posedge i_clk);
		case (k)
			0: i_cmp_one <= on;
			1: i_cmp_two <= on;
			default: i_int_pin <= !on;
		endcase
	endtask : drive_src

	// Count edges until a pin reaches a level
	task automatic wait_pin(input int i, input logic v, output int n);
		n = 0;
		while (pin[i] !== v) begin
			@(posedge i_clk);
			#1 n++;
			if (n > 60) begin
				failures++;
				wrap_up();
			end
		end
	endtask : wait_pin

	// Pulse the period start once
	task automatic period;
		@(posedge i_clk);
		i_period_start <= 1'b1;
		@(posedge i_clk);
		i_period_start <= 1'b0;
		repeat (2) @(posedge i_clk);
	endtask : period

	task automatic t_reset;
		for (int a = 0; a < 6; a++) begin
			rdchk(3'(a), 8'h00);
		end
		chk({pin, oe}, 8'h0F);
		$display("reset values done");
	endtask : t_reset

	task automatic t_regs;
		wr(3'h0, 8'h3F);
		rdchk(3'h0, 8'h3F);
		wr(3'h1, 8'hFF);
		rdchk(3'h1, 8'hFF);
		wr(3'h2, 8'hA5);
		rdchk(3'h2, 8'hA5);
		wr(3'h5, 8'hFF);
		rdchk(3'h5, 8'h00);
		$display("register access done");
	endtask : t_regs

	// Every select code against every source, with auto restart
	task automatic t_sources;
		logic [2:0] s;
		wr(3'h1, 8'h80);
		for (int i = 0; i < 8; i++) begin
			s = 3'(i);
			wr(3'h0, {1'b0, s, 4'h0});
			for (int k = 0; k < 3; k++) begin
				drive_src(k, 1'b1);
				rdchk(3'h0, {s[k], s, 4'h0});
				rdchk(3'h0, {s[k], s, 4'h0});
				drive_src(k, 1'b0);
				rdchk(3'h0, {1'b0, s, 4'h0});
			end
		end
		$display("source select done");
	endtask : t_sources

	// Firmware restart, safe states, interrupt and period alignment
	task automatic t_shutdown;
		@(posedge i_clk);
		{i_pwm_d, i_pwm_c, i_pwm_b, i_pwm_a} <= 4'hA;
		wr(3'h1, 8'h00);
		wr(3'h3, 8'h03);
		wr(3'h4, 8'h01);
		wr(3'h0, 8'h16);
		drive_src(0, 1'b1);
		repeat (3) @(posedge i_clk);
		#1 chk({pin, oe}, 8'h55);
		chk({7'h00, o_irq}, 8'h01);
		wr(3'h0, 8'h16);
		rdchk(3'h0, 8'h96);
		drive_src(0, 1'b0);
		repeat (3) @(posedge i_clk);
		rdchk(3'h0, 8'h96);
		wr(3'h0, 8'h16);
		rdchk(3'h0, 8'h16);
		rdchk(3'h3, 8'h03);
		wr(3'h3, 8'h01);
		rdchk(3'h3, 8'h02);
		chk({7'h00, o_irq}, 8'h00);
		wr(3'h3, 8'h02);
		rdchk(3'h3, 8'h00);
		chk({pin, oe}, 8'h55);
		period();
		#1 chk({pin, oe}, 8'hAF);
		wr(3'h0, 8'h80);
		repeat (2) @(posedge i_clk);
		#1 chk({pin, oe}, 8'h0F);
		rdchk(3'h0, 8'h80);
		wr(3'h0, 8'h00);
		period();
		$display("shutdown and restart done");
	endtask : t_shutdown

	// Half-bridge with a dead-band of three cycles
	task automatic t_deadband;
		int n;
		int m;
		wr(3'h1, 8'h03);
		@(posedge i_clk);
		i_half_bridge <= 1'b1;
		i_pwm_a <= 1'b0;
		repeat (8) @(posedge i_clk);
		#1 chk({pin, oe}, 8'h23);
		@(posedge i_clk);
		i_pwm_a <= 1'b1;
		#1 wait_pin(1, 1'b0, n);
		wait_pin(0, 1'b1, m);
		chk(8'(n), 8'h01);
		chk(8'(n + m), 8'h04);
		@(posedge i_clk);
		i_pwm_a <= 1'b0;
		#1 wait_pin(0, 1'b0, n);
		wait_pin(1, 1'b1, m);
		chk(8'(n), 8'h01);
		chk(8'(n + m), 8'h04);
		@(posedge i_clk);
		i_pwm_a <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_pwm_a <= 1'b0;
		repeat (6) begin
			@(posedge i_clk);
			#1 chk({7'h00, pin[0]}, 8'h00);
		end
		$display("dead-band done");
	endtask : t_deadband

	// Main sequence
	initial begin
		repeat (10) @(posedge i_clk);
		i_rst <= 1'b0;
		t_reset();
		t_regs();
		t_sources();
		t_shutdown();
		t_deadband();
		wrap_up();
	end
endmodule : pwmsd_top_tb_top

`default_nettype wire
